// [design/afcd_pkg.sv]
// package: constants and types for the filter config and download block
// What this block does
// (RULE_01) a register write is an address word, then one 16-bit data word
// (RULE_02) main control sits at address 0x0001 and resets to 0x001A
// (RULE_03) bit 15 set makes following writes coefficient words until checksum
// (RULE_04) host sets tap count code bits 8..5 in the same load write
// (RULE_05) bit 14 makes the next read return the overrange threshold
// (RULE_06) bit 13 makes the next read return the gain register
// (RULE_07) bit 12 makes the next read return the offset register
// (RULE_08) bit 11 makes the next read return the status register
// (RULE_09) host always writes zero into bit 10
// (RULE_10) bit 9 starts an internal filter synchronisation routine
// (RULE_11) bits 15..9 clear themselves after acting
// (RULE_12) bit 4 zero bypasses the third programmable stage
// (RULE_13) bit 3 zero bypasses the first stage, for raw modulator data
// (RULE_14) rate field 0 bypasses stage two, n=1..5 decimates by 2^n
// (RULE_15) host sends coefficients centre outwards, upper word first
// (RULE_16) after checksum, unused slots zeroed, half a clock each (here one whole clock each); host waits
// (RULE_17) checksum is the sum of every byte of the coefficient words
// (RULE_18) host verifies by status read and testing bit 7
// (RULE_19) device sums up to 192 bytes; good flag set only on match
// (RULE_20) tap code 0 is default, odd codes give 12..96 taps, half downloaded
// (RULE_21) coefficient is 27-bit sign-magnitude split into two words
// (RULE_22) user coefficients volatile, lost on reset, default set applies
// (RULE_23) after checksum and zero-fill the device returns to address/data
package afcd_pkg;
    // ------------------------------------------------------------
    // addresses and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_MAIN_CTRL = 16'h0001;
    localparam logic [15:0] ADDR_CLK_PWR = 16'h0002;
    localparam logic [15:0] ADDR_OFFSET = 16'h0003;
    localparam logic [15:0] ADDR_GAIN = 16'h0004;
    localparam logic [15:0] ADDR_THRESH = 16'h0005;
    localparam logic [15:0] RST_MAIN_CTRL = 16'h001A;
    localparam logic [15:0] RST_CLK_PWR = 16'h009B;
    localparam logic [15:0] RST_OFFSET = 16'h0000;
    localparam logic [15:0] RST_GAIN = 16'hA000;
    localparam logic [15:0] RST_THRESH = 16'hCCCC;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_LOAD = 15;
    localparam int BIT_RD_THR = 14;
    localparam int BIT_RD_GAIN = 13;
    localparam int BIT_RD_OFF = 12;
    localparam int BIT_RD_STAT = 11;
    localparam int BIT_SYNC = 9;
    localparam int TAP_LSB = 5;
    localparam int BIT_F3 = 4;
    localparam int BIT_F1 = 3;
    localparam int BIT_CP_LPWR = 2;
    localparam int ST_GOOD = 7;
    localparam int ST_USER = 5;
    localparam int ST_LPWR = 9;
    localparam logic [15:0] SELF_CLR_MASK = 16'hFE00;
    localparam logic [2:0] RATE_MAX = 3'h5;
    localparam int MAX_COEFS = 48;
    localparam int COEF_W = 27;
    // ------------------------------------------------------------
    // timing: zero slot of half a clock period, rounded up to one whole cycle
    // ------------------------------------------------------------
    localparam real CLK_PERIOD_NS = 10.0;
    localparam real ZERO_SLOT_NS = 5.0;
    localparam int ZERO_SLOT_CYC = (ZERO_SLOT_NS < CLK_PERIOD_NS) ? 1 :
        int'(ZERO_SLOT_NS / CLK_PERIOD_NS);
    localparam int SYNC_CYC = 4;
    // ------------------------------------------------------------
    // state machine and read source
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_ADDR = 5'h01,
        ST_DATA = 5'h02,
        ST_HI = 5'h04,
        ST_LO = 5'h08,
        ST_FILL = 5'h10
    } afcd_state_t;
    typedef enum logic [2:0] {
        RS_CONV = 3'h0,
        RS_THR = 3'h1,
        RS_GAIN = 3'h2,
        RS_OFF = 3'h3,
        RS_STAT = 3'h4
    } afcd_rsel_t;
endpackage : afcd_pkg

// [design/afcd_coef_if.sv]
// interface: coefficient store write port
`timescale 1ns/1ps
interface afcd_coef_if;
    logic we;
    logic clear;
    logic [5:0] idx;
    logic [26:0] data;
    modport ctrl (output we, output clear, output idx, output data);
    modport store (input we, input clear, input idx, input data);
endinterface : afcd_coef_if

// [design/afcd_coef_store.sv]
// module: volatile user coefficient storage
`timescale 1ns/1ps
module afcd_coef_store
    import afcd_pkg::*;
#(
    parameter int DEPTH = MAX_COEFS
) (
    input wire logic clk,
    input wire logic rst,
    afcd_coef_if.store wr,
    input wire logic [5:0] rd_idx,
    output logic [26:0] rd_data
);
    logic [26:0] mem_q [DEPTH];
    // lost on reset, so the default set applies afterwards [RULE_22]
    always_ff @(posedge clk) begin
        if (rst || wr.clear) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (wr.we && int'(wr.idx) < DEPTH) begin
            mem_q[wr.idx] <= wr.data;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= '0;
        end else if (int'(rd_idx) < DEPTH) begin
            rd_data <= mem_q[rd_idx];
        end else begin
            rd_data <= '0;
        end
    end
endmodule : afcd_coef_store

// [design/afcd_top.sv]
// module: main control register and coefficient download sequencer
`timescale 1ns/1ps
module afcd_top
    import afcd_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic WR_N_IN,
    input wire logic RD_N_IN,
    input wire logic [15:0] DATA_IN,
    input wire logic [15:0] CONV_DATA_IN,
    input wire logic OVR_IN,
    input wire logic [5:0] COEF_RD_IDX_IN,
    output logic [15:0] DATA_OUT,
    output logic [26:0] COEF_RD_DATA_OUT,
    output logic THIRD_STAGE_ENABLE_OUT,
    output logic FIRST_STAGE_ENABLE_OUT,
    output logic [2:0] RATE_OUT,
    output logic USER_FILTER_OUT,
    output logic [3:0] TAP_COUNT_CODE_OUT,
    output logic SYNC_OUT,
    output logic LOAD_BUSY_OUT
);
    // ------------------------------------------------------------
    // pin synchronisers and strobe edges
    // ------------------------------------------------------------
    logic [1:0] wr_sync_q, rd_sync_q;
    logic [15:0] din_s1_q, din_s2_q;
    logic wr_prev_q, rd_prev_q;
    logic wr_pulse, rd_pulse;
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            wr_sync_q <= 2'h3;
            rd_sync_q <= 2'h3;
            din_s1_q <= '0;
            din_s2_q <= '0;
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
        end else begin
            wr_sync_q <= {wr_sync_q[0], WR_N_IN};
            rd_sync_q <= {rd_sync_q[0], RD_N_IN};
            din_s1_q <= DATA_IN;
            din_s2_q <= din_s1_q;
            wr_prev_q <= wr_sync_q[1];
            rd_prev_q <= rd_sync_q[1];
        end
    end
    // act on the rising edge, when data has long settled
    assign wr_pulse = wr_sync_q[1] && !wr_prev_q;
    assign rd_pulse = rd_sync_q[1] && !rd_prev_q;
    // ------------------------------------------------------------
    // tap count decode: odd codes give 6..48 coefficients
    // ------------------------------------------------------------
    function automatic logic [5:0] coef_count(input logic [3:0] code);
        coef_count = code[0] ? 6'((int'(code[3:1]) + 1) * 6) : 6'h00;
    endfunction : coef_count
    // ------------------------------------------------------------
    // registers and sequencer
    // ------------------------------------------------------------
    afcd_state_t state_q;
    afcd_rsel_t rsel_q;
    logic [15:0] addr_q, ctrl_q, cpwr_q, off_q, gain_q, thr_q;
    logic [15:0] hi_q, sum_q;
    logic [5:0] idx_q, ncoef_q;
    logic [7:0] wait_q;
    logic good_q, user_q;
    logic [2:0] sync_cnt_q;
    afcd_coef_if cif ();
    assign cif.clear = 1'b0;
    function automatic logic [15:0] byte_sum(input logic [15:0] w);
        byte_sum = {8'h00, w[15:8]} + {8'h00, w[7:0]};
    endfunction : byte_sum
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            state_q <= ST_ADDR;
            addr_q <= '0;
            ctrl_q <= RST_MAIN_CTRL; // [RULE_02]
            cpwr_q <= RST_CLK_PWR;
            off_q <= RST_OFFSET;
            gain_q <= RST_GAIN;
            thr_q <= RST_THRESH;
            rsel_q <= RS_CONV;
            hi_q <= '0;
            sum_q <= '0;
            idx_q <= '0;
            ncoef_q <= '0;
            wait_q <= '0;
            good_q <= 1'b0;
            user_q <= 1'b0; // [RULE_22]
            sync_cnt_q <= '0;
            cif.we <= 1'b0;
            cif.idx <= '0;
            cif.data <= '0;
        end else begin
            cif.we <= 1'b0;
            if (sync_cnt_q != 3'h0) begin
                sync_cnt_q <= sync_cnt_q - 3'h1;
            end
            // one-shot read select, cleared once the read is served
            if (rd_pulse) begin
                rsel_q <= RS_CONV;
            end
            case (state_q)
                ST_ADDR: begin
                    if (wr_pulse) begin
                        addr_q <= din_s2_q; // [RULE_01]
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (wr_pulse) begin
                        state_q <= ST_ADDR; // [RULE_01]
                        case (addr_q)
                            ADDR_MAIN_CTRL: begin
                                // action bits never stored [RULE_11]
                                ctrl_q <= din_s2_q & ~SELF_CLR_MASK;
                                if (din_s2_q[BIT_RD_THR]) begin
                                    rsel_q <= RS_THR; // [RULE_05]
                                end else if (din_s2_q[BIT_RD_GAIN]) begin
                                    rsel_q <= RS_GAIN; // [RULE_06]
                                end else if (din_s2_q[BIT_RD_OFF]) begin
                                    rsel_q <= RS_OFF; // [RULE_07]
                                end else if (din_s2_q[BIT_RD_STAT]) begin
                                    rsel_q <= RS_STAT; // [RULE_08]
                                end
                                if (din_s2_q[BIT_SYNC]) begin
                                    sync_cnt_q <= 3'(SYNC_CYC); // [RULE_10]
                                end
                                if (din_s2_q[BIT_LOAD]) begin
                                    // tap code taken from this write [RULE_04]
                                    ncoef_q <= coef_count(
                                        din_s2_q[TAP_LSB +: 4]); // [RULE_20]
                                    idx_q <= '0;
                                    sum_q <= '0;
                                    good_q <= 1'b0;
                                    state_q <= ST_HI; // [RULE_03]
                                end
                            end
                            ADDR_CLK_PWR: cpwr_q <= din_s2_q;
                            ADDR_OFFSET: off_q <= din_s2_q;
                            ADDR_GAIN: gain_q <= din_s2_q;
                            ADDR_THRESH: thr_q <= din_s2_q;
                            default: ;
                        endcase
                    end
                end
                ST_HI: begin
                    if (wr_pulse) begin
                        if (idx_q == ncoef_q) begin
                            // checksum word [RULE_19]
                            good_q <= (din_s2_q == sum_q);
                            user_q <= (ncoef_q != 6'h00);
                            wait_q <= 8'((MAX_COEFS - int'(idx_q))
                                * ZERO_SLOT_CYC);
                            state_q <= ST_FILL; // [RULE_16]
                        end else begin
                            hi_q <= din_s2_q; // upper word first [RULE_15]
                            sum_q <= sum_q + byte_sum(din_s2_q); // [RULE_17]
                            state_q <= ST_LO;
                        end
                    end
                end
                ST_LO: begin
                    if (wr_pulse) begin
                        sum_q <= sum_q + byte_sum(din_s2_q); // [RULE_17]
                        cif.we <= 1'b1;
                        cif.idx <= idx_q;
                        // sign and magnitude 25..16, then 15..0 [RULE_21]
                        cif.data <= {hi_q[10:0], din_s2_q};
                        idx_q <= idx_q + 6'h01;
                        state_q <= ST_HI;
                    end
                end
                ST_FILL: begin
                    // zero the unused slots, one per slot time [RULE_16]
                    if (int'(idx_q) < MAX_COEFS) begin
                        cif.we <= 1'b1;
                        cif.idx <= idx_q;
                        cif.data <= '0;
                        idx_q <= idx_q + 6'h01;
                    end
                    if (wait_q > 8'h01) begin
                        wait_q <= wait_q - 8'h01;
                    end else begin
                        state_q <= ST_ADDR; // [RULE_23]
                    end
                end
                default: state_q <= ST_ADDR;
            endcase
        end
    end
    afcd_coef_store #(.DEPTH(MAX_COEFS)) u_store (
        .clk(SYS_CLK_IN),
        .rst(SYS_RST_IN),
        .wr(cif.store),
        .rd_idx(COEF_RD_IDX_IN),
        .rd_data(COEF_RD_DATA_OUT)
    );
    // ------------------------------------------------------------
    // read data and status
    // ------------------------------------------------------------
    logic [15:0] status;
    always_comb begin
        status = '0;
        status[ST_LPWR] = cpwr_q[BIT_CP_LPWR];
        status[8] = OVR_IN;
        status[ST_GOOD] = good_q; // [RULE_19]
        status[ST_USER] = user_q;
        status[4:0] = ctrl_q[4:0];
    end
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            DATA_OUT <= '0;
        end else begin
            case (rsel_q)
                RS_THR: DATA_OUT <= thr_q; // [RULE_05]
                RS_GAIN: DATA_OUT <= gain_q; // [RULE_06]
                RS_OFF: DATA_OUT <= off_q; // [RULE_07]
                RS_STAT: DATA_OUT <= status; // [RULE_08]
                default: DATA_OUT <= CONV_DATA_IN;
            endcase
        end
    end
    // rate above 5 is not defined; clamped to the 32x maximum
    assign THIRD_STAGE_ENABLE_OUT = ctrl_q[BIT_F3]; // [RULE_12]
    assign FIRST_STAGE_ENABLE_OUT = ctrl_q[BIT_F1]; // [RULE_13]
    assign RATE_OUT = (ctrl_q[2:0] > RATE_MAX) ? RATE_MAX
        : ctrl_q[2:0]; // [RULE_14]
    assign USER_FILTER_OUT = user_q;
    assign TAP_COUNT_CODE_OUT = ctrl_q[TAP_LSB +: 4];
    assign SYNC_OUT = (sync_cnt_q != 3'h0); // [RULE_10]
    assign LOAD_BUSY_OUT = (state_q == ST_HI) || (state_q == ST_LO)
        || (state_q == ST_FILL);
endmodule : afcd_top

// [testbench/afcd_monitor.sv]
// checker: port-level assertions for the filter config block
`timescale 1ns/1ps
module afcd_monitor
    import afcd_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic WR_N_IN,
    input wire logic RD_N_IN,
    input wire logic [15:0] CONV_DATA_IN,
    input wire logic [15:0] DATA_OUT,
    input wire logic THIRD_STAGE_ENABLE_OUT,
    input wire logic FIRST_STAGE_ENABLE_OUT,
    input wire logic [2:0] RATE_OUT,
    input wire logic [3:0] TAP_COUNT_CODE_OUT,
    input wire logic SYNC_OUT,
    input wire logic LOAD_BUSY_OUT
);
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // ------------------------------------------------------------
    // strobe age: strobes pass a two-flop sync, so effects lag
    // ------------------------------------------------------------
    logic wr_q;
    logic rd_q;
    logic [7:0] age_q;
    logic [8:0] cfg;
    assign cfg = {THIRD_STAGE_ENABLE_OUT, FIRST_STAGE_ENABLE_OUT, RATE_OUT,
        TAP_COUNT_CODE_OUT};
    always_ff @(posedge SYS_CLK_IN) begin
        wr_q <= WR_N_IN;
        rd_q <= RD_N_IN;
    end
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN || (!wr_q && WR_N_IN)) begin
            age_q <= 8'h00;
        end else if (age_q != 8'hFF) begin
            age_q <= age_q + 8'h01;
        end
    end
    a_rate_clamped: assert property (RATE_OUT <= 3'h5)
        else $error("rate field above five");
    a_reset_values: assert property ($fell(SYS_RST_IN) |->
        cfg == 9'h1A0 && !SYNC_OUT && !LOAD_BUSY_OUT)
        else $error("control outputs wrong after reset");
    a_sync_pulse: assert property ($rose(SYNC_OUT) |->
        SYNC_OUT [*4] ##1 !SYNC_OUT)
        else $error("sync pulse length wrong");
    a_sync_cause: assert property ($rose(SYNC_OUT) |->
        age_q <= 8'h06)
        else $error("sync without a write");
    a_busy_cause: assert property ($rose(LOAD_BUSY_OUT) |->
        age_q <= 8'h06)
        else $error("load mode without a write");
    a_cfg_quiet: assert property ((age_q > 8'h07 &&
        !LOAD_BUSY_OUT) |-> $stable(cfg))
        else $error("control outputs moved without a write");
    a_fill_bounded: assert property ($fell(LOAD_BUSY_OUT) |->
        age_q <= 8'h3C)
        else $error("zero fill too long");
    a_read_restore: assert property ((!rd_q && RD_N_IN) |->
        ##[1:6] DATA_OUT == CONV_DATA_IN)
        else $error("read select not cleared");
    c_download: cover property ($rose(LOAD_BUSY_OUT));
    c_fill_done: cover property ($fell(LOAD_BUSY_OUT));
    c_sync: cover property ($rose(SYNC_OUT));
endmodule : afcd_monitor

bind afcd_top afcd_monitor u_mon (.SYS_CLK_IN(SYS_CLK_IN),
    .SYS_RST_IN(SYS_RST_IN), .WR_N_IN(WR_N_IN), .RD_N_IN(RD_N_IN),
    .CONV_DATA_IN(CONV_DATA_IN), .DATA_OUT(DATA_OUT),
    .THIRD_STAGE_ENABLE_OUT(THIRD_STAGE_ENABLE_OUT),
    .FIRST_STAGE_ENABLE_OUT(FIRST_STAGE_ENABLE_OUT), .RATE_OUT(RATE_OUT),
    .TAP_COUNT_CODE_OUT(TAP_COUNT_CODE_OUT), .SYNC_OUT(SYNC_OUT),
    .LOAD_BUSY_OUT(LOAD_BUSY_OUT));

// [testbench/afcd_host_model.sv]
// host model: drives the parallel word port with strobes
`timescale 1ns/1ps
module afcd_host_model (
    input wire logic clk_in,
    input wire logic [15:0] rd_data_in,
    output logic wr_n_out,
    output logic rd_n_out,
    output logic [15:0] wdata_out
);
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    initial begin
        wr_n_out = 1'b1;
        rd_n_out = 1'b1;
        wdata_out = 16'hFFFF;
    end
    // data settles 3 cycles before the rising strobe; inverted once released
    task automatic wr(input logic [15:0] w);
        @(posedge clk_in);
        #1 wdata_out = w;
        @(posedge clk_in);
        #1 wr_n_out = 1'b0;
        repeat (2) @(posedge clk_in);
        #1 wr_n_out = 1'b1;
        repeat (2) @(posedge clk_in);
        #1 wdata_out = ~w;
        repeat (3) @(posedge clk_in);
    endtask : wr
    task automatic reg_wr(input logic [15:0] a,
        input logic [15:0] d);
        wr(a);
        wr(d);
    endtask : reg_wr
    task automatic rd(output logic [15:0] v);
        @(posedge clk_in);
        #1 rd_n_out = 1'b0;
        repeat (2) @(posedge clk_in);
        #1 v = rd_data_in;
        rd_n_out = 1'b1;
        repeat (4) @(posedge clk_in);
    endtask : rd
    // centre outwards, upper word first; bias spoils the checksum on purpose
    task automatic load(input logic [15:0] c [24], input logic [15:0] bias,
        output logic [15:0] sum);
        sum = 16'h0000;
        reg_wr(16'h0001, 16'h8079);
        foreach (c[i]) begin
            wr(c[i]);
            sum = sum + {8'h00, c[i][15:8]} + {8'h00, c[i][7:0]};
        end
        wr(sum + bias);
    endtask : load
endmodule : afcd_host_model

// [testbench/tb.sv]
// testbench: control register, read select and filter download
`timescale 1ns/1ps
module tb;
    import afcd_pkg::*;
    localparam logic [15:0] CONV = 16'h5A3C;
    logic clk, rst, wr_n, rd_n, f3, f1, uf, sy, busy, sync_seen, busy_seen;
    logic [15:0] wdata, dout, v, sum;
    logic [5:0] cidx;
    logic [26:0] cdat;
    logic [2:0] rate;
    logic [3:0] tap;
    int fails;
    int n_compared;
    logic [15:0] coef [24] = '{16'h032B, 16'h9688, 16'h01BF, 16'h183C,
        16'h0015, 16'h6626, 16'h04A8, 16'h1E6A, 16'h045F, 16'h2A96, 16'h002C,
        16'h49C2, 16'h0050, 16'hE9F6, 16'h0010, 16'hDBD8, 16'h042F, 16'hDE54,
        16'h0437, 16'h445A, 16'h041B, 16'h7D6E, 16'h0404, 16'h3B5F};
    logic [15:0] r_in [6] = '{16'h0000, 16'h001F, 16'h0015, 16'h01E3,
        16'h00AC, 16'h0208};
    logic [8:0] r_exp [6] = '{9'h000, 9'h1D0, 9'h150, 9'h03F, 9'h0C5, 9'h080};
    logic [15:0] sel_adr [3] = '{16'h0005, 16'h0004, 16'h0003};
    logic [15:0] sel_rst [3] = '{16'hCCCC, 16'hA000, 16'h0000};
    afcd_top u_dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .WR_N_IN(wr_n),
        .RD_N_IN(rd_n), .DATA_IN(wdata), .CONV_DATA_IN(CONV), .OVR_IN(1'b0),
        .COEF_RD_IDX_IN(cidx), .DATA_OUT(dout), .COEF_RD_DATA_OUT(cdat),
        .THIRD_STAGE_ENABLE_OUT(f3), .FIRST_STAGE_ENABLE_OUT(f1),
        .RATE_OUT(rate), .USER_FILTER_OUT(uf), .TAP_COUNT_CODE_OUT(tap),
        .SYNC_OUT(sy), .LOAD_BUSY_OUT(busy));
    afcd_host_model u_host (.clk_in(clk), .rd_data_in(dout),
        .wr_n_out(wr_n), .rd_n_out(rd_n), .wdata_out(wdata));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (sy === 1'b1) sync_seen <= 1'b1;
        if (busy === 1'b1) busy_seen <= 1'b1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    // fill length is bounded, so a stuck busy ends the run
    task automatic wait_idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 200) begin
            @(posedge clk);
            k++;
        end
        if (k >= 200) begin
            fails++;
            print_verdict();
        end
    endtask : wait_idle
    task automatic peek(input logic [5:0] i);
        @(posedge clk);
        #1 cidx = i;
        repeat (2) @(posedge clk);
        #1;
    endtask : peek
    initial begin
        #1000000;
        fails++;
        print_verdict();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        cidx = 6'h00;
        fails = 0;
        n_compared = 0;
        sync_seen = 1'b0;
        busy_seen = 1'b0;
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        #1 check({f3, f1, rate, tap, sy, busy, uf}, 12'hD00);
        check(dout, CONV);
        for (int i = 0; i < 6; i++) begin
            u_host.reg_wr(16'h0001, r_in[i]);
            check({f3, f1}, r_exp[i][8:7]);
            check({rate, tap}, r_exp[i][6:0]);
        end
        check(sync_seen, 1'b1);
        for (int k = 0; k < 3; k++) begin
            u_host.reg_wr(16'h0001, 16'h001A | (16'h4000 >> k));
            check({f3, f1, rate, tap}, 9'h1A0);
            u_host.rd(v);
            check(v, sel_rst[k]);
            u_host.rd(v);
            check(v, CONV);
            u_host.reg_wr(sel_adr[k], 16'h1230 + 16'(k));
            u_host.reg_wr(16'h0001, 16'h001A | (16'h4000 >> k));
            u_host.rd(v);
            check(v, 16'h1230 + 16'(k));
        end
        u_host.load(coef, 16'h0000, sum);
        check(sum, 16'h0E6B);
        wait_idle();
        check(busy_seen, 1'b1);
        check({f3, f1, uf, rate, tap}, 10'h393);
        u_host.reg_wr(16'h0002, 16'h009F);
        u_host.reg_wr(16'h0001, 16'h0879);
        // unmapped pair is consumed and must leave control untouched
        u_host.reg_wr(16'h0007, 16'h0000);
        u_host.rd(v);
        check(v[ST_GOOD], 1'b1);
        check(v[ST_LPWR], 1'b1);
        check(v[4:0], 5'h19);
        peek(6'h00);
        check(cdat, 27'h32B9688);
        peek(6'h0B);
        check(cdat, 27'h4043B5F);
        peek(6'h0C);
        check(cdat, 27'h0000000);
        u_host.load(coef, 16'h0001, sum);
        wait_idle();
        u_host.reg_wr(16'h0001, 16'h0879);
        u_host.rd(v);
        check(v[ST_GOOD], 1'b0);
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        peek(6'h00);
        check(cdat, 27'h0000000);
        check(uf, 1'b0);
        print_verdict();
    end
endmodule : tb
